//--- verilog/spi_cfg_pkg.sv
// Purpose: Shared constants for the serial port configuration block.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: Prescale encodings and register offsets are local decisions.
`default_nettype none
package spi_cfg_pkg;
    localparam logic [11:0] CTRL1_OFFSET = 12'h000;
    localparam logic [11:0] DATA_OFFSET = 12'h004;
    localparam logic [11:0] STATUS_OFFSET = 12'h008;
    localparam logic [11:0] CONFIG_OFFSET = 12'h00C;
    localparam int CTRL1_WIDTH = 13;
    localparam logic [12:0] CTRL1_RESET = 13'h0000;
    localparam int CLK_PIN_DIS_BIT = 12;
    localparam int DATA_OUT_DIS_BIT = 11;
    localparam int WORD_WIDTH_BIT = 10;
    localparam int SAMPLE_PHASE_BIT = 9;
    localparam int OUT_EDGE_BIT = 8;
    localparam int SEL_PIN_EN_BIT = 7;
    localparam int CLK_POL_BIT = 6;
    localparam int CTRL_ROLE_BIT = 5;
    localparam int SEC_PRE_LSB = 2;
    localparam int PRI_PRE_LSB = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_RX_FULL_BIT = 1;
    localparam int STAT_OVERFLOW_BIT = 2;
    localparam int CFG_ENABLE_BIT = 0;
    localparam int CFG_FRAMED_BIT = 1;
    localparam logic [1:0] CONFIG_RESET = 2'h0;
    localparam int BYTE_BITS = 8;
    localparam int WORD_BITS = 16;
    localparam int RATIO_WIDTH = 10;
    localparam int SYNC_STAGES = 2;
endpackage : spi_cfg_pkg
`default_nettype wire

//--- verilog/sync_2ff.sv
// Purpose: Two-stage synchroniser for pin inputs.
// Assumes: Inputs are asynchronous levels.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
    parameter int WIDTH = 3
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;
    initial begin
        if (WIDTH < 1) begin
            $error("sync_2ff: WIDTH must be at least 1");
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // sync_2ff
`default_nettype wire

//--- verilog/clk_divider.sv
// Purpose: Half-period tick generator for the serial clock.
// Assumes: ratio is the full serial clock period in system clock cycles.
// Notes: Odd ratios give a slightly longer second half.
`timescale 1ns/1ps
`default_nettype none
module clk_divider #(
    parameter int WIDTH = 10
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic run,
    input wire logic [WIDTH-1:0] ratio,
    output logic half_tick
);
    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] half_point;
    initial begin
        if (WIDTH < 2) begin
            $error("clk_divider: WIDTH must be at least 2");
        end
    end
    assign half_point = ratio >> 1;
    always_ff @(posedge clk) begin
        if (srst || !run) begin
            count_r <= '0;
        end else if (count_r >= ratio - 1'b1) begin
            count_r <= '0;
        end else begin
            count_r <= count_r + 1'b1;
        end
    end
    always_comb begin
        half_tick = run && ((count_r == (ratio - 1'b1)) || (count_r == half_point - 1'b1 && half_point != '0));
    end
endmodule // clk_divider
`default_nettype wire

//--- verilog/spi_port.sv
// Purpose: Serial port with controller and peripheral roles, configured over APB.
// Assumes: SPI pins are asynchronous to SYS_CLK and pass two flip-flops first.
// Notes: Serial clock period in controller role is the prescale product in SYS_CLK cycles.
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module spi_port
    import spi_cfg_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SCK_IN,
    output logic SCK_OUT,
    output logic SCK_OE,
    output logic SDO_OUT,
    output logic SDO_OE,
    input wire logic SDI_IN,
    input wire logic SS_N_IN
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CTRL = 3'b010,
        ST_PERI = 3'b100
    } state_e;

    state_e state_r;
    logic [CTRL1_WIDTH-1:0] ctrl1_r;
    logic [1:0] config_r;
    logic [WORD_BITS-1:0] tx_hold_r;
    logic [WORD_BITS-1:0] tx_shift_r;
    logic [WORD_BITS-1:0] rx_shift_r;
    logic [WORD_BITS-1:0] rx_buf_r;
    logic rx_full_r;
    logic overflow_r;
    logic tx_pending_r;
    logic sck_r;
    logic [5:0] half_r;
    logic [4:0] bits_r;
    logic sck_prev_r;
    logic [2:0] pins_sync;
    logic sck_s;
    logic sdi_s;
    logic ss_n_s;
    logic half_tick;
    logic [RATIO_WIDTH-1:0] ratio;
    logic [RATIO_WIDTH-1:0] pri_ratio;
    logic [RATIO_WIDTH-1:0] sec_ratio;
    logic setup_ph;
    logic access_ph;
    logic addr_ok;
    logic wr_data;
    logic rd_data;
    logic wr_status;
    logic enabled;
    logic is_ctrl;
    logic word_mode;
    logic late_sample;
    logic cke;
    logic cpol;
    logic [5:0] nbits;
    logic [5:0] last_half;
    logic [5:0] soff;
    logic ctl_sample;
    logic ctl_shift;
    logic ctl_done;
    logic sel_active;
    logic lead_edge;
    logic trail_edge;
    logic per_sample;
    logic per_shift;
    logic per_done;
    logic done;
    logic [WORD_BITS-1:0] rx_next;
    logic [WORD_BITS-1:0] rx_last;

    sync_2ff #(.WIDTH(3)) u_sync (
        .clk(SYS_CLK),
        .srst(SRST),
        .async_in({SCK_IN, SDI_IN, SS_N_IN}),
        .sync_out(pins_sync)
    );
    assign sck_s = pins_sync[2];
    assign sdi_s = pins_sync[1];
    assign ss_n_s = pins_sync[0];

    // Primary: 4^(3-code); secondary: 8-code. Product is the serial clock period.
    assign pri_ratio = RATIO_WIDTH'(1) << (2 * (3 - ctrl1_r[PRI_PRE_LSB +: 2]));
    assign sec_ratio = RATIO_WIDTH'(4'd8 - {1'b0, ctrl1_r[SEC_PRE_LSB +: 3]});
    assign ratio = RATIO_WIDTH'(pri_ratio * sec_ratio);

    clk_divider #(.WIDTH(RATIO_WIDTH)) u_div (
        .clk(SYS_CLK),
        .srst(SRST),
        .run(state_r == ST_CTRL),
        .ratio(ratio),
        .half_tick(half_tick)
    );

    assign enabled = config_r[CFG_ENABLE_BIT];
    assign is_ctrl = ctrl1_r[CTRL_ROLE_BIT];
    assign word_mode = ctrl1_r[WORD_WIDTH_BIT];
    assign late_sample = ctrl1_r[SAMPLE_PHASE_BIT] && is_ctrl;
    assign cke = ctrl1_r[OUT_EDGE_BIT] && !config_r[CFG_FRAMED_BIT];
    assign cpol = ctrl1_r[CLK_POL_BIT];
    assign nbits = word_mode ? 6'(WORD_BITS) : 6'(BYTE_BITS);

    // Controller timing over half periods: even halves are leading edges.
    assign soff = {5'd0, !cke} + {5'd0, late_sample};
    assign last_half = (nbits << 1) - 6'd1 + {5'd0, !cke && late_sample};
    assign ctl_sample = state_r == ST_CTRL && half_tick && half_r >= soff && !(half_r[0] ^ soff[0]);
    assign ctl_shift = state_r == ST_CTRL && half_tick && (cke ? half_r[0] : (!half_r[0] && half_r != 6'd0));
    assign ctl_done = state_r == ST_CTRL && half_tick && half_r == last_half;

    // Peripheral timing from the synchronised clock pin.
    assign sel_active = ctrl1_r[SEL_PIN_EN_BIT] ? !ss_n_s : 1'b1;
    assign lead_edge = (sck_s != sck_prev_r) && (sck_s != cpol);
    assign trail_edge = (sck_s != sck_prev_r) && (sck_s == cpol);
    assign per_sample = state_r == ST_PERI && sel_active && (cke ? lead_edge : trail_edge);
    assign per_shift = state_r == ST_PERI && sel_active && (cke ? trail_edge : (lead_edge && bits_r != 5'd0));
    assign per_done = per_sample && (6'(bits_r) == nbits - 6'd1);
    assign done = ctl_done || per_done;
    assign rx_next = {rx_shift_r[WORD_BITS-2:0], sdi_s};
    // A controller frame may end half a period after its last sample, so only a sampling cycle adds a bit.
    assign rx_last = (ctl_sample || per_sample) ? rx_next : rx_shift_r;

    assign setup_ph = PSEL && !PENABLE;
    assign access_ph = PSEL && PENABLE;
    assign addr_ok = PADDR == CTRL1_OFFSET || PADDR == DATA_OFFSET || PADDR == STATUS_OFFSET ||
                     PADDR == CONFIG_OFFSET;
    assign wr_data = access_ph && PWRITE && PADDR == DATA_OFFSET;
    assign rd_data = access_ph && !PWRITE && PADDR == DATA_OFFSET;
    assign wr_status = access_ph && PWRITE && PADDR == STATUS_OFFSET;
    assign PREADY = 1'b1;
    assign PSLVERR = access_ph && !addr_ok;

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            ctrl1_r <= CTRL1_RESET;
            config_r <= CONFIG_RESET;
        end else if (access_ph && PWRITE) begin
            if (PADDR == CTRL1_OFFSET) begin
                ctrl1_r <= PWDATA[CTRL1_WIDTH-1:0];
            end
            if (PADDR == CONFIG_OFFSET) begin
                config_r <= PWDATA[1:0];
            end
        end
    end

    // Read data is captured in the setup cycle so it comes from a flip-flop.
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            PRDATA <= 32'h0000_0000;
        end else if (setup_ph && !PWRITE) begin
            case (PADDR)
                CTRL1_OFFSET: PRDATA <= {19'd0, ctrl1_r};
                DATA_OFFSET: PRDATA <= {16'd0, rx_buf_r};
                STATUS_OFFSET: PRDATA <= {29'd0, overflow_r, rx_full_r, state_r != ST_IDLE};
                CONFIG_OFFSET: PRDATA <= {30'd0, config_r};
                default: PRDATA <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            tx_hold_r <= '0;
            tx_pending_r <= 1'b0;
        end else if (wr_data) begin
            tx_hold_r <= PWDATA[WORD_BITS-1:0];
            tx_pending_r <= 1'b1;
        end else if (state_r == ST_IDLE && enabled && tx_pending_r && is_ctrl) begin
            tx_pending_r <= 1'b0;
        end else if (state_r == ST_PERI && bits_r == 5'd0 && !per_sample && tx_pending_r) begin
            tx_pending_r <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            rx_buf_r <= '0;
            rx_full_r <= 1'b0;
            overflow_r <= 1'b0;
        end else begin
            if (done) begin
                rx_buf_r <= word_mode ? rx_last : {8'd0, rx_last[BYTE_BITS-1:0]};
            end
            // A completion in the same cycle as the read keeps the flag set.
            if (done) begin
                rx_full_r <= 1'b1;
            end else if (rd_data) begin
                rx_full_r <= 1'b0;
            end
            if (done && rx_full_r && !rd_data) begin
                overflow_r <= 1'b1;
            end else if (wr_status && PWDATA[STAT_OVERFLOW_BIT]) begin
                overflow_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            state_r <= ST_IDLE;
        end else if (!enabled) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (is_ctrl && tx_pending_r) begin
                        state_r <= ST_CTRL;
                    end else if (!is_ctrl) begin
                        state_r <= ST_PERI;
                    end
                end
                ST_CTRL: begin
                    if (ctl_done) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_PERI: begin
                    if (is_ctrl) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            half_r <= '0;
            sck_r <= 1'b0;
        end else if (state_r != ST_CTRL) begin
            half_r <= '0;
            sck_r <= cpol;
        end else if (half_tick) begin
            half_r <= half_r + 6'd1;
            if (half_r < (nbits << 1)) begin
                sck_r <= ~sck_r;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            bits_r <= '0;
            sck_prev_r <= 1'b0;
        end else begin
            sck_prev_r <= sck_s;
            if (state_r != ST_PERI || !sel_active || per_done) begin
                bits_r <= '0;
            end else if (per_sample) begin
                bits_r <= bits_r + 5'd1;
            end
        end
    end

    // The transmit word is left aligned so its top bit always drives the pin.
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            tx_shift_r <= '0;
            rx_shift_r <= '0;
        end else begin
            if (ctl_sample || per_sample) begin
                rx_shift_r <= rx_next;
            end
            if (state_r == ST_IDLE || (state_r == ST_PERI && bits_r == 5'd0 && !per_sample)) begin
                if (state_r == ST_IDLE || tx_pending_r) begin
                    tx_shift_r <= word_mode ? tx_hold_r : {tx_hold_r[BYTE_BITS-1:0], 8'd0};
                end
            end else if (ctl_shift || per_shift) begin
                tx_shift_r <= {tx_shift_r[WORD_BITS-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            SCK_OUT <= 1'b0;
            SCK_OE <= 1'b0;
            SDO_OUT <= 1'b0;
            SDO_OE <= 1'b0;
        end else begin
            SCK_OUT <= sck_r;
            SCK_OE <= enabled && is_ctrl && !ctrl1_r[CLK_PIN_DIS_BIT];
            SDO_OUT <= tx_shift_r[WORD_BITS-1];
            SDO_OE <= enabled && !ctrl1_r[DATA_OUT_DIS_BIT] && (is_ctrl || sel_active);
        end
    end
endmodule // spi_port
`default_nettype wire

//--- bench/spi_port_properties.sv
// Purpose: Port-level assertions for the serial port block.
// Assumes: Only top-level ports are visible; shadows follow control writes.
// Notes: Bound into spi_port below the module.
`timescale 1ns/1ps
`default_nettype none
module spi_port_properties
    import spi_cfg_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic SCK_OUT,
    input wire logic SCK_OE,
    input wire logic SDO_OE
);
    logic [12:0] ctrl_r;
    logic en_r;
    logic sck_q_r;
    logic [8:0] idle_r;
    logic wr_w;
    logic map_w;
    logic cpol_w;
    logic sckdis_w;
    logic sdodis_w;
    assign wr_w = PSEL && PENABLE && PWRITE;
    assign map_w = PADDR inside {CTRL1_OFFSET, DATA_OFFSET, STATUS_OFFSET, CONFIG_OFFSET};
    assign cpol_w = ctrl_r[CLK_POL_BIT];
    assign sckdis_w = ctrl_r[CLK_PIN_DIS_BIT] || !ctrl_r[CTRL_ROLE_BIT];
    assign sdodis_w = ctrl_r[DATA_OUT_DIS_BIT];
    always_ff @(posedge SYS_CLK) begin
        if (SRST)
            ctrl_r <= CTRL1_RESET;
        else if (wr_w && PADDR == CTRL1_OFFSET)
            ctrl_r <= PWDATA[12:0];
    end
    always_ff @(posedge SYS_CLK) begin
        if (SRST)
            en_r <= 1'b0;
        else if (wr_w && PADDR == CONFIG_OFFSET)
            en_r <= PWDATA[CFG_ENABLE_BIT];
    end
    always_ff @(posedge SYS_CLK) begin
        sck_q_r <= SCK_OUT;
    end
    // Counts quiet cycles on the serial clock, saturating.
    always_ff @(posedge SYS_CLK) begin
        if (SRST || SCK_OUT != sck_q_r)
            idle_r <= '0;
        else if (idle_r != 9'h1FF)
            idle_r <= idle_r + 9'd1;
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SRST);
    sequence access_s;
        PSEL && PENABLE;
    endsequence
    sequence ctrl_wr_s;
        wr_w && PADDR == CTRL1_OFFSET && en_r && PWDATA[CTRL_ROLE_BIT] && !PWDATA[DATA_OUT_DIS_BIT];
    endsequence
    sequence ctrl_clk_wr_s;
        wr_w && PADDR == CTRL1_OFFSET && en_r && PWDATA[CTRL_ROLE_BIT] && !PWDATA[CLK_PIN_DIS_BIT];
    endsequence
    chk_ready_high: assert property (PREADY) else $error("ready low");
    chk_err_in_access: assert property (PSLVERR |-> PSEL && PENABLE) else $error("error outside access");
    chk_err_unmapped: assert property (access_s |-> PSLVERR == !map_w) else $error("error flag wrong");
    chk_unmapped_zero: assert property (access_s ##0 (!map_w && !PWRITE) |-> PRDATA == '0)
        else $error("unmapped read not zero");
    chk_ctrl_readback: assert property (access_s ##0 (PADDR == CTRL1_OFFSET && !PWRITE) |-> PRDATA == 32'(ctrl_r))
        else $error("control readback wrong");
    chk_sck_oe_cause: assert property (SCK_OE |-> !$past(sckdis_w) && $past(en_r))
        else $error("clock pin driven while released");
    chk_sdo_oe_cause: assert property (SDO_OE |-> !$past(sdodis_w) && $past(en_r))
        else $error("data pin driven while released");
    chk_sdo_oe_take: assert property (ctrl_wr_s |-> ##[1:3] SDO_OE)
        else $error("data pin not taken");
    chk_sck_oe_take: assert property (ctrl_clk_wr_s |-> ##[1:3] SCK_OE)
        else $error("clock pin not taken");
    chk_sck_idle_level: assert property (idle_r == 9'd300 && SCK_OE |-> SCK_OUT == $past(cpol_w, 4))
        else $error("clock idle level wrong");
endmodule // spi_port_properties
bind spi_port spi_port_properties spi_port_properties_inst (.SYS_CLK(SYS_CLK), .SRST(SRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SCK_OUT(SCK_OUT), .SCK_OE(SCK_OE), .SDO_OE(SDO_OE));
`default_nettype wire

//--- bench/spi_peripheral_model.sv
// Purpose: Behavioural serial peripheral on the far side of the port.
// Assumes: Samples on leading edges when cke is 1 and on trailing edges otherwise; changes on the other edge.
// Notes: After the last bit the data line toggles instead of holding.
`timescale 1ns/1ps
`default_nettype none
module spi_peripheral_model (
    input wire logic sck,
    input wire logic sdo,
    input wire logic cpol,
    input wire logic cke,
    input wire logic [4:0] nbits,
    input wire logic [15:0] tx_word,
    input wire logic load,
    output logic sdi,
    output logic [15:0] rx_word
);
    int idx;
    bit armed;
    initial sdi = 1'b1;
    always @(posedge load) begin
        idx = int'(nbits) - 1;
        sdi = tx_word[idx];
        rx_word = '0;
        armed = 1'b0;
    end
    // The line moves only after a sample, so the first leading edge of a cke 0 frame keeps the top bit.
    always @(sck) begin
        if ((sck !== cpol) == cke) begin
            rx_word = {rx_word[14:0], sdo};
            armed = 1'b1;
        end
        else if (armed && idx > 0) begin
            armed = 1'b0;
            idx = idx - 1;
            sdi = tx_word[idx];
        end
        else if (armed) begin
            armed = 1'b0;
            sdi = ~sdi;
        end
    end
endmodule // spi_peripheral_model
`default_nettype wire

//--- bench/spi_port_test.sv
// Purpose: Self-checking bench for the serial port over APB.
// Assumes: Zero wait state slave; controller transfers against a model peer.
// Notes: Clock input is held idle and select is only lowered at the end; peripheral role is only configured.
`timescale 1ns/1ps
`default_nettype none
module spi_port_test;
    import spi_cfg_pkg::*;
    logic SYS_CLK, SRST, PSEL, PENABLE, PWRITE, SCK_IN, SS_N_IN, m_load;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd_q;
    logic PREADY, PSLVERR, SCK_OUT, SCK_OE, SDO_OUT, SDO_OE, m_sdi, err_q;
    logic [15:0] m_tx, m_rx;
    logic [4:0] m_n;
    logic m_cp, m_cke;
    int mismatches;
    int checks;
    spi_port spi_port_inst (.SYS_CLK(SYS_CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SCK_IN(SCK_IN),
        .SCK_OUT(SCK_OUT), .SCK_OE(SCK_OE), .SDO_OUT(SDO_OUT), .SDO_OE(SDO_OE), .SDI_IN(m_sdi), .SS_N_IN(SS_N_IN));
    spi_peripheral_model spi_peripheral_model_inst (.sck(SCK_OUT), .sdo(SDO_OUT), .cpol(m_cp), .cke(m_cke),
        .nbits(m_n), .tx_word(m_tx), .load(m_load), .sdi(m_sdi), .rx_word(m_rx));
    always #2.5 SYS_CLK = ~SYS_CLK;
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        @(posedge SYS_CLK);
        while (PREADY !== 1'b1) @(posedge SYS_CLK);
        rd_q = PRDATA;
        err_q = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic xfer(input logic [12:0] ctl, input logic [15:0] dout, input logic [15:0] din, input int half);
        logic [15:0] m;
        logic cp;
        int n;
        m = ctl[WORD_WIDTH_BIT] ? 16'hFFFF : 16'h00FF;
        cp = ctl[CLK_POL_BIT];
        apb(1'b1, CTRL1_OFFSET, 32'(ctl));
        repeat (4) @(posedge SYS_CLK);
        check("sck idle", 32'(SCK_OUT), 32'(cp));
        check("sck oe", 32'(SCK_OE), 32'h0000_0001);
        check("sdo oe", 32'(SDO_OE), 32'h0000_0001);
        m_tx <= din;
        m_cp <= cp;
        m_cke <= ctl[OUT_EDGE_BIT];
        m_n <= ctl[WORD_WIDTH_BIT] ? 5'd16 : 5'd8;
        m_load <= 1'b1;
        @(posedge SYS_CLK);
        m_load <= 1'b0;
        apb(1'b1, DATA_OFFSET, 32'(dout));
        n = 0;
        while (SCK_OUT === cp && n < 300) begin
            @(posedge SYS_CLK);
            n++;
        end
        n = 0;
        while (SCK_OUT !== cp && n < 300) begin
            @(posedge SYS_CLK);
            n++;
        end
        check("half period", 32'(n), 32'(half));
        n = 0;
        do begin
            apb(1'b0, STATUS_OFFSET, '0);
            n++;
        end while (rd_q[STAT_BUSY_BIT] !== 1'b0 && n < 100);
        check("peer rx", 32'(m_rx), 32'(dout & m));
        apb(1'b0, DATA_OFFSET, '0);
        check("port rx", rd_q, 32'(din & m));
    endtask
    initial begin
        #200000;
        mismatches++;
        conclude;
    end
    initial begin
        {SYS_CLK, PSEL, PENABLE, PWRITE, SCK_IN, m_load} = '0;
        {PADDR, PWDATA, m_tx} = '0;
        {SRST, SS_N_IN} = 2'b11;
        m_n = 5'd8;
        m_cp = 1'b0;
        m_cke = 1'b0;
        repeat (10) @(posedge SYS_CLK);
        SRST <= 1'b0;
        apb(1'b0, CTRL1_OFFSET, '0);
        check("ctrl1 reset", rd_q, 32'(CTRL1_RESET));
        apb(1'b0, CONFIG_OFFSET, '0);
        check("config reset", rd_q, 32'(CONFIG_RESET));
        apb(1'b1, CTRL1_OFFSET, 32'hFFFF_FFFC);
        apb(1'b0, CTRL1_OFFSET, '0);
        check("ctrl1 rw", rd_q, 32'h0000_1FFC);
        check("oe while off", 32'({SCK_OE, SDO_OE}), 32'h0000_0000);
        apb(1'b1, 12'h010, 32'h0000_0001);
        check("wr err", 32'(err_q), 32'h0000_0001);
        apb(1'b0, 12'h010, '0);
        check("rd err", 32'(err_q), 32'h0000_0001);
        check("rd unmapped", rd_q, 32'h0000_0000);
        apb(1'b1, CONFIG_OFFSET, 32'h0000_0001);
        xfer(13'h013D, 16'h7EA5, 16'h003C, 8);
        xfer(13'h0576, 16'hC3A5, 16'h5A96, 6);
        repeat (320) @(posedge SYS_CLK);
        apb(1'b1, CTRL1_OFFSET, 32'h0000_193D);
        repeat (4) @(posedge SYS_CLK);
        check("sck oe off", 32'(SCK_OE), 32'h0000_0000);
        check("sdo oe off", 32'(SDO_OE), 32'h0000_0000);
        apb(1'b1, CTRL1_OFFSET, 32'h0000_001D);
        repeat (4) @(posedge SYS_CLK);
        check("sck oe periph", 32'(SCK_OE), 32'h0000_0000);
        check("sdo oe periph", 32'(SDO_OE), 32'h0000_0001);
        apb(1'b1, CTRL1_OFFSET, 32'h0000_009D);
        repeat (4) @(posedge SYS_CLK);
        check("sdo oe deselected", 32'(SDO_OE), 32'h0000_0000);
        SS_N_IN <= 1'b0;
        repeat (5) @(posedge SYS_CLK);
        check("sdo oe selected", 32'(SDO_OE), 32'h0000_0001);
        conclude;
    end
endmodule // spi_port_test
`default_nettype wire
